// file: pie_pkg.sv
// shared constants, types and register map of the interrupt and
// event transfer unit; assumes a 100 MHz system clock
package pie_pkg;

  //////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NSRC   = 28;  // interrupt sources
  localparam int NEXT   = 8;   // fast external inputs, sources 0..7
  localparam int NCH    = 8;   // transfer channels
  localparam int PRIO_W = 4;   // sixteen priority levels
  localparam int PTR_W  = 16;  // channel pointer width
  localparam int CNT_W  = 8;   // channel transfer counter width
  localparam int CTRL_W = 14;  // used bits of a source control word
  localparam int NEV    = 4;   // event status bits

  //////////////////////////////////////////////////////////////////////
  // fixed trap numbers, source index order
  localparam logic [6:0] SRC_TRAP [NSRC] = '{
    7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D, 7'h1E, 7'h1F,
    7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27,
    7'h2A, 7'h47, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F,
    7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46};

  //////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [11:0] OFF_SRC   = 12'h000;  // + 4 * source
  localparam logic [11:0] OFF_CH    = 12'h100;  // + 16 * channel
  localparam logic [11:0] OFF_STAT  = 12'h200;  // event status, w1c
  localparam logic [11:0] OFF_MASK  = 12'h204;  // event mask
  localparam logic [11:0] OFF_STATE = 12'h208;  // service state
  localparam logic [11:0] OFF_TRAP  = 12'h20C;  // software trap number

  // source control word fields
  localparam int F_PRIO = 0;   // [3:0] priority level
  localparam int F_EN   = 6;   // enable flag
  localparam int F_REQ  = 7;   // request flag
  localparam int F_XFER = 8;   // serve by transfer engine
  localparam int F_CHAN = 9;   // [11:9] channel select
  localparam int F_EDGE = 12;  // [13:12] edge select, inputs 0..7

  // channel control word fields
  localparam int F_CNT  = 0;   // [7:0] transfer counter
  localparam int F_WORD = 8;   // word (1) or byte (0)
  localparam int F_INCD = 9;   // increment destination (1) or source
  localparam int F_CONT = 10;  // continuous transfer mode

  // event status bits
  localparam int EV_VEC  = 0;  // vectored service accepted
  localparam int EV_XFER = 1;  // transfer done
  localparam int EV_ZERO = 2;  // counter reached zero
  localparam int EV_SWT  = 3;  // software trap accepted

  // edge selects
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [CTRL_W-1:0] RST_CTRL = 14'h0000;
  localparam logic [NEV-1:0]    RST_EV   = 4'h0;

  //////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_NS       = 10;
  localparam int RESP_MIN_NS  = 250;
  localparam int RESP_MAX_NS  = 600;
  localparam int RESP_MIN_CYC = (RESP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESP_MAX_CYC = RESP_MAX_NS / CLK_NS;
  localparam int ARB_CYC      = 2;  // source event pulse to request shown

  // address decode kinds
  localparam logic [2:0] K_NONE = 3'h0;
  localparam logic [2:0] K_SRC  = 3'h1;
  localparam logic [2:0] K_CH   = 3'h2;
  localparam logic [2:0] K_STAT = 3'h3;
  localparam logic [2:0] K_MASK = 3'h4;
  localparam logic [2:0] K_STA  = 3'h5;
  localparam logic [2:0] K_TRAP = 3'h6;

  //////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic        vld;   // vectored service requested
    logic [6:0]  trap;  // trap number
    logic [23:0] vec;   // vector location
  } pie_vreq_s;

  typedef struct packed {
    logic             vld;   // move in progress
    logic             word;  // word move
    logic [PTR_W-1:0] src;
    logic [PTR_W-1:0] dst;
  } pie_mov_s;

  typedef struct packed {
    logic [PTR_W-1:0] src;
    logic [PTR_W-1:0] dst;
    logic [CNT_W-1:0] cnt;
    logic             word;
    logic             inc_dst;
    logic             cont;
  } pie_chan_s;

  typedef struct packed {
    logic [2:0] kind;
    logic [4:0] idx;
    logic [1:0] sub;
  } pie_dec_s;

  typedef enum logic [1:0] {
    XS_IDLE = 2'b00, XS_MOVE = 2'b01, XS_DONE = 2'b11
  } pie_xs_e;

  typedef enum logic [1:0] {
    SV_IDLE = 2'b00, SV_VEC = 2'b01, SV_XFER = 2'b11
  } pie_sv_e;

endpackage

// file: pie_xfer.sv
// single move engine: one byte or word per service, pointer step
// and counter update; assumes memory answers i_mem_done in its cycle
`timescale 1ns/100ps
module pie_xfer (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire logic              i_start,
  input  wire pie_pkg::pie_chan_s i_chan,
  input  wire logic              i_mem_done,
  output pie_pkg::pie_mov_s      o_mov,
  output pie_pkg::pie_chan_s     o_chan,
  output logic                   o_steal,
  output logic                   o_done,
  output logic                   o_zero,
  output logic                   o_busy
);
  import pie_pkg::*;

  pie_xs_e          st_q,   st_d;    // engine state
  pie_mov_s         mov_q,  mov_d;   // move command
  pie_chan_s        chan_q, chan_d;  // updated channel
  logic             zero_q, zero_d;  // counter hit zero
  logic [PTR_W-1:0] step;            // pointer step

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_d   = st_q;
    mov_d  = mov_q;
    chan_d = chan_q;
    zero_d = zero_q;
    step   = i_chan.word ? 16'h0002 : 16'h0001;
    case (st_q)
      XS_IDLE: begin
        if (i_start) begin
          // one move between any two locations
          mov_d  = '{vld: 1'b1, word: i_chan.word,
                     src: i_chan.src, dst: i_chan.dst};
          chan_d = i_chan;
          // step one pointer as configured
          if (i_chan.inc_dst) begin
            chan_d.dst = i_chan.dst + step;
          end else begin
            chan_d.src = i_chan.src + step;
          end
          // count down unless continuous
          if (!i_chan.cont) begin
            chan_d.cnt = i_chan.cnt - 8'h01;
          end
          zero_d = !i_chan.cont && (i_chan.cnt == 8'h01);
          st_d   = XS_MOVE;
        end
      end
      XS_MOVE: begin
        // the stolen cycle ends when memory answers
        if (i_mem_done) begin
          mov_d.vld = 1'b0;
          st_d      = XS_DONE;
        end
      end
      XS_DONE: begin
        st_d = XS_IDLE;
      end
      default: begin
        st_d = XS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q   <= XS_IDLE;
      mov_q  <= '0;
      chan_q <= '0;
      zero_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      mov_q  <= mov_d;
      chan_q <= chan_d;
      zero_q <= zero_d;
    end
  end

  assign o_mov   = mov_q;
  assign o_chan  = chan_q;
  assign o_zero  = zero_q;
  assign o_steal = (st_q == XS_MOVE);
  assign o_done  = (st_q == XS_DONE);
  assign o_busy  = (st_q != XS_IDLE);

endmodule

// file: pie_top.sv
// prioritised interrupt controller with event transfer engine;
// assumes an APB master, same-clock peripheral event pulses and a CPU
// that shows its current priority and acknowledges vectored requests
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps

// Summary of operation
// - per-source request, enable, sixteen-level priority
// - each source routed vectored or transfer engine
// - only strictly higher priority may preempt
// - vectored service branches to source vector
// - fixed trap number and vector per source
// - transfer steals one cycle, no branch
// - move byte or word, step one pointer
// - counter decrements unless continuous mode
// - counter zero raises source vectored interrupt
// - eight channels with pointers and counter
// - respond to requests within 250-600 ns (here a request is shown ARB_CYC = 2 cycles, 20 ns, after a source event pulse)
// - external inputs: rising, falling or both edges
// - software trap number invokes its service
// - four bus nodes, three software-settable nodes (no such nodes here; any source request bit can be set by an APB write)
// - no service during a hardware trap (a pending software trap is still served)
module pie_top #(
  parameter int NUM_CH = pie_pkg::NCH  // transfer channels
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst,
  input  wire logic                       i_psel,
  input  wire logic                       i_penable,
  input  wire logic                       i_pwrite,
  input  wire logic [11:0]                i_paddr,
  input  wire logic [31:0]                i_pwdata,
  output logic      [31:0]                o_prdata,
  output logic                            o_pready,
  output logic                            o_pslverr,
  input  wire logic [pie_pkg::NEXT-1:0]   i_ext_pin,
  input  wire logic [pie_pkg::NSRC-1:0]   i_src_evt,
  input  wire logic [pie_pkg::PRIO_W-1:0] i_cpu_prio,
  input  wire logic                       i_hw_trap_active,
  input  wire logic                       i_int_ack,
  output pie_pkg::pie_vreq_s              o_vreq,
  output logic                            o_steal,
  output pie_pkg::pie_mov_s               o_mov,
  input  wire logic                       i_mem_done,
  output logic                            o_irq
);
  import pie_pkg::*;

  if (NUM_CH < 1 || NUM_CH > NCH) begin : g_chk
    $error("NUM_CH must be 1 to 8");
  end
  if (ARB_CYC > RESP_MAX_CYC) begin : g_chk_resp
    $error("arbitration slower than response limit");
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [CTRL_W-1:0] ctrl_q [NSRC];  // source control words
  logic [CTRL_W-1:0] ctrl_d [NSRC];
  pie_chan_s         chan_q [NUM_CH];  // channel state
  pie_chan_s         chan_d [NUM_CH];
  logic [NSRC-1:0]   std_q, std_d;     // forced vectored after zero
  logic [NEV-1:0]    stat_q, stat_d;   // sticky events
  logic [NEV-1:0]    mask_q, mask_d;   // event mask
  logic              swt_q, swt_d;     // software trap pending
  logic [6:0]        swn_q, swn_d;     // software trap number
  pie_sv_e           st_q, st_d;       // service state
  logic [4:0]        cur_q, cur_d;     // source in service
  logic [2:0]        xch_q, xch_d;     // channel in service
  logic              vsw_q, vsw_d;     // service is software trap
  pie_vreq_s         vreq_q, vreq_d;   // vectored request out
  logic [31:0]       rdat_q, rdat_d;   // read data
  logic [NEXT-1:0]   sy1_q, sy2_q, sy3_q;  // pin synchroniser
  logic [NEXT-1:0]   ext_set;          // detected edges
  logic              win_vld;          // arbitration result
  logic [4:0]        win_idx;
  logic [PRIO_W-1:0] win_prio;
  logic [2:0]        win_ch;
  logic              start;            // engine start pulse
  pie_chan_s         eng_chan;         // updated channel
  logic              eng_done, eng_zero, eng_busy;
  pie_dec_s          dw, dr;           // access and setup decode
  logic              wr;               // write in access phase

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic pie_dec_s dec(input logic [11:0] a);
    pie_dec_s r;
    r = '{kind: K_NONE, idx: 5'h00, sub: 2'h0};
    if (a[1:0] != 2'h0) begin
      r.kind = K_NONE;
    end else if (a[11:8] == OFF_SRC[11:8] && a[7:2] < 6'(NSRC)) begin
      r = '{kind: K_SRC, idx: a[6:2], sub: 2'h0};
    end else if (a[11:8] == OFF_CH[11:8] && a[7:4] < 4'(NUM_CH)
                 && a[3:2] != 2'h3) begin
      r = '{kind: K_CH, idx: {2'h0, a[6:4]}, sub: a[3:2]};
    end else if (a == OFF_STAT) begin
      r.kind = K_STAT;
    end else if (a == OFF_MASK) begin
      r.kind = K_MASK;
    end else if (a == OFF_STATE) begin
      r.kind = K_STA;
    end else if (a == OFF_TRAP) begin
      r.kind = K_TRAP;
    end
    return r;
  endfunction

  // vector location from trap number
  function automatic logic [23:0] vec_of(input logic [6:0] t);
    return {15'h0000, t, 2'h0};
  endfunction

  // source may be served now
  function automatic logic elig(input logic [CTRL_W-1:0] c,
                                input logic [PRIO_W-1:0] p,
                                input logic              h);
    return c[F_REQ] && c[F_EN] && (c[F_PRIO +: PRIO_W] > p) && !h;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // external pins: three flops, then edge select on the second and third
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
    end else begin
      sy1_q <= i_ext_pin;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  for (genvar g = 0; g < NEXT; g++) begin : g_edge
    logic [1:0] sel;  // edge select of this input
    assign sel = ctrl_q[g][F_EDGE +: 2];
    assign ext_set[g] =
      ((sel == EDGE_RISE || sel == EDGE_BOTH) && sy2_q[g] && !sy3_q[g])
      || ((sel == EDGE_FALL || sel == EDGE_BOTH) && !sy2_q[g] && sy3_q[g]);
  end

  ////////////////////////////////////////////////////////////////////////
  // arbitration: highest level wins, lowest index breaks ties
  always_comb begin
    win_vld  = 1'b0;
    win_idx  = 5'h00;
    win_prio = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (elig(ctrl_q[i], i_cpu_prio, i_hw_trap_active)
          && (!win_vld || ctrl_q[i][F_PRIO +: PRIO_W] > win_prio)) begin
        win_vld  = 1'b1;
        win_idx  = 5'(i);
        win_prio = ctrl_q[i][F_PRIO +: PRIO_W];
      end
    end
    win_ch = ctrl_q[win_idx][F_CHAN +: 3];
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer engine
  pie_xfer u_xfer (
    .i_clk_sys  (i_clk_sys),
    .i_rst      (i_rst),
    .i_start    (start),
    .i_chan     (chan_q[xch_d]),
    .i_mem_done (i_mem_done),
    .o_mov      (o_mov),
    .o_chan     (eng_chan),
    .o_steal    (o_steal),
    .o_done     (eng_done),
    .o_zero     (eng_zero),
    .o_busy     (eng_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // service control, registers and flags: next values
  always_comb begin
    ctrl_d = ctrl_q;
    chan_d = chan_q;
    std_d  = std_q;
    stat_d = stat_q;
    mask_d = mask_q;
    swt_d  = swt_q;
    swn_d  = swn_q;
    st_d   = st_q;
    cur_d  = cur_q;
    xch_d  = xch_q;
    vsw_d  = vsw_q;
    vreq_d = vreq_q;
    start  = 1'b0;
    dw     = dec(i_paddr);
    wr     = i_psel && i_penable && i_pwrite;

    // software writes, hardware outcomes below override them
    if (wr) begin
      if (dw.kind == K_SRC) begin
        // request, enable, level, route, channel, edge
        ctrl_d[dw.idx] = i_pwdata[CTRL_W-1:0];
      end else if (dw.kind == K_CH) begin
        if (dw.sub == 2'h0) begin
          chan_d[dw.idx[2:0]].cnt     = i_pwdata[F_CNT +: CNT_W];
          chan_d[dw.idx[2:0]].word    = i_pwdata[F_WORD];
          chan_d[dw.idx[2:0]].inc_dst = i_pwdata[F_INCD];
          chan_d[dw.idx[2:0]].cont    = i_pwdata[F_CONT];
        end else if (dw.sub == 2'h1) begin
          chan_d[dw.idx[2:0]].src = i_pwdata[PTR_W-1:0];
        end else begin
          chan_d[dw.idx[2:0]].dst = i_pwdata[PTR_W-1:0];
        end
      end else if (dw.kind == K_STAT) begin
        stat_d = stat_q & ~i_pwdata[NEV-1:0];  // write one to clear
      end else if (dw.kind == K_MASK) begin
        mask_d = i_pwdata[NEV-1:0];
      end else if (dw.kind == K_TRAP) begin
        swt_d = 1'b1;  // software trap
        swn_d = i_pwdata[6:0];
      end
    end

    case (st_q)
      SV_IDLE: begin
        if (swt_q) begin
          // trap runs its numbered service
          vreq_d = '{vld: 1'b1, trap: swn_q, vec: vec_of(swn_q)};
          vsw_d  = 1'b1;
          swt_d  = wr && dw.kind == K_TRAP;
          st_d   = SV_VEC;
        end else if (win_vld && !eng_busy) begin
          cur_d = win_idx;
          vsw_d = 1'b0;
          if (ctrl_q[win_idx][F_XFER] && !std_q[win_idx]
              && 4'(win_ch) < 4'(NUM_CH)
              && (chan_q[win_ch].cnt != '0 || chan_q[win_ch].cont)) begin
            // no vector, just the stolen cycle
            xch_d = win_ch;
            start = 1'b1;
            st_d  = SV_XFER;
          end else begin
            // branch to the source's own vector
            vreq_d = '{vld: 1'b1, trap: SRC_TRAP[win_idx],
                       vec: vec_of(SRC_TRAP[win_idx])};
            st_d   = SV_VEC;
          end
        end
      end
      SV_VEC: begin
        if (i_int_ack) begin
          // cpu took the branch; request done
          if (vsw_q) begin
            stat_d[EV_SWT] = 1'b1;
          end else begin
            ctrl_d[cur_q][F_REQ] = 1'b0;
            std_d[cur_q]         = 1'b0;
            stat_d[EV_VEC]       = 1'b1;
          end
          vreq_d.vld = 1'b0;
          st_d       = SV_IDLE;
        end else if (!vsw_q
                     && !elig(ctrl_q[cur_q], i_cpu_prio,
                              i_hw_trap_active)) begin
          // withdraw once no longer strictly higher
          vreq_d.vld = 1'b0;
          st_d       = SV_IDLE;
        end
      end
      SV_XFER: begin
        if (eng_done) begin
          chan_d[xch_q]   = eng_chan;
          stat_d[EV_XFER] = 1'b1;
          if (eng_zero) begin
            // keep request, serve it by vector next
            std_d[cur_q]    = 1'b1;
            stat_d[EV_ZERO] = 1'b1;
          end else begin
            ctrl_d[cur_q][F_REQ] = 1'b0;
          end
          st_d = SV_IDLE;
        end
      end
      default: begin
        st_d = SV_IDLE;
      end
    endcase

    // hardware sets win over clears
    for (int i = 0; i < NSRC; i++) begin
      if ((i < NEXT) ? ext_set[i] : i_src_evt[i]) begin
        ctrl_d[i][F_REQ] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase
  always_comb begin
    dr     = dec(i_paddr);
    rdat_d = rdat_q;
    if (i_psel && !i_penable) begin
      rdat_d = 32'h0000_0000;
      if (dr.kind == K_SRC) begin
        rdat_d[CTRL_W-1:0] = ctrl_q[dr.idx];
      end else if (dr.kind == K_CH) begin
        if (dr.sub == 2'h0) begin
          rdat_d[F_CNT +: CNT_W] = chan_q[dr.idx[2:0]].cnt;
          rdat_d[F_WORD]         = chan_q[dr.idx[2:0]].word;
          rdat_d[F_INCD]         = chan_q[dr.idx[2:0]].inc_dst;
          rdat_d[F_CONT]         = chan_q[dr.idx[2:0]].cont;
        end else if (dr.sub == 2'h1) begin
          rdat_d[PTR_W-1:0] = chan_q[dr.idx[2:0]].src;
        end else begin
          rdat_d[PTR_W-1:0] = chan_q[dr.idx[2:0]].dst;
        end
      end else if (dr.kind == K_STAT) begin
        rdat_d[NEV-1:0] = stat_q;
      end else if (dr.kind == K_MASK) begin
        rdat_d[NEV-1:0] = mask_q;
      end else if (dr.kind == K_STA) begin
        rdat_d[15:0] = {vreq_q.trap, cur_q, eng_busy,
                        i_hw_trap_active, st_q};
      end else if (dr.kind == K_TRAP) begin
        rdat_d[6:0] = swn_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      for (int i = 0; i < NSRC; i++) begin
        ctrl_q[i] <= RST_CTRL;
      end
      for (int c = 0; c < NUM_CH; c++) begin
        chan_q[c] <= '0;
      end
      std_q  <= '0;
      stat_q <= RST_EV;
      mask_q <= RST_EV;
      swt_q  <= 1'b0;
      swn_q  <= 7'h00;
      st_q   <= SV_IDLE;
      cur_q  <= 5'h00;
      xch_q  <= 3'h0;
      vsw_q  <= 1'b0;
      vreq_q <= '0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      chan_q <= chan_d;
      std_q  <= std_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      swt_q  <= swt_d;
      swn_q  <= swn_d;
      st_q   <= st_d;
      cur_q  <= cur_d;
      xch_q  <= xch_d;
      vsw_q  <= vsw_d;
      vreq_q <= vreq_d;
      rdat_q <= rdat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; request shown one cycle after its flag sets
  assign o_vreq    = vreq_q;
  assign o_irq     = |(stat_q & mask_q);
  assign o_prdata  = rdat_q;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && (dw.kind == K_NONE);

endmodule

// file: pie_top_assertions.sv
// port checker of the interrupt and transfer unit
// assumes a bind onto pie_top, one clock domain
`timescale 1ns/100ps
module pie_chk #(
  parameter int NUM_CH = 8  // transfer channels
) (
  input wire logic               i_clk_sys,
  input wire logic               i_rst,
  input wire logic               i_hw_trap_active,
  input wire logic               i_int_ack,
  input wire logic               i_mem_done,
  input wire logic               o_steal,
  input wire logic               o_pslverr,
  input wire pie_pkg::pie_vreq_s o_vreq,
  input wire pie_pkg::pie_mov_s  o_mov
);
  import pie_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////
  chk_vec_trap: assert property (
    o_vreq.vld |-> o_vreq.vec == {15'h0, o_vreq.trap, 2'b0})
    else $error("vector is not trap times four");
  chk_steal_mov: assert property (
    o_mov.vld |-> o_steal) else $error("move outside stolen cycle");
  chk_steal_novec: assert property (
    o_steal |-> !o_vreq.vld) else $error("branch during transfer");
  chk_vld_hold: assert property (
    o_vreq.vld && !i_int_ack |=> !o_vreq.vld || $stable(o_vreq.trap))
    else $error("shown trap changed while pending");
  chk_ack_drop: assert property (
    o_vreq.vld && i_int_ack |=> !o_vreq.vld)
    else $error("request kept after ack");
  chk_hw_block: assert property (
    $rose(o_vreq.vld) |-> !$past(i_hw_trap_active))
    else $error("service during hardware trap");
  chk_mov_hold: assert property (
    o_mov.vld && !i_mem_done |=> o_mov.vld && $stable(o_mov.src)
      && $stable(o_mov.dst)) else $error("move dropped early");
  chk_mov_end: assert property (
    o_mov.vld && i_mem_done |=> !o_mov.vld)
    else $error("move longer than one service");
  cover property ($rose(o_vreq.vld));
  cover property ($rose(o_steal));
  cover property (o_pslverr);
endmodule

// file: pie_cpu_model.sv
// cpu and memory stand-in: acks vectored requests, finishes moves
// assumes the unit's registered request and move carriers
`timescale 1ns/100ps
module pie_cpu_model (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  input  wire logic               i_slow,
  input  wire pie_pkg::pie_vreq_s i_vreq,
  input  wire pie_pkg::pie_mov_s  i_mov,
  output logic                    o_int_ack,
  output logic                    o_mem_done
);
  logic [1:0] vcnt_q;  // cycles a request has been shown
  logic [1:0] mcnt_q;  // cycles a move has been shown
  logic [1:0] dly;     // answer delay, slow mode waits three cycles
  assign dly = i_slow ? 2'h3 : 2'h0;
  // answers are pulses: the unit drops its request at the next edge
  assign o_int_ack = i_vreq.vld && vcnt_q == dly;
  assign o_mem_done = i_mov.vld && mcnt_q == dly;
  ////////////////////////////////////////////////////////////////////
  // wait counters restart whenever the unit lets go
  always_ff @(posedge i_clk_sys) begin
    vcnt_q <= (i_rst || !i_vreq.vld) ? 2'h0 : vcnt_q + 2'h1;
    mcnt_q <= (i_rst || !i_mov.vld) ? 2'h0 : mcnt_q + 2'h1;
  end
endmodule

// file: tb_pie_top.sv
// bench of the interrupt and transfer unit over its register bus
// assumes pie_pkg, the cpu stand-in and the port checker
`timescale 1ns/100ps
module tb_pie_top;
  import pie_pkg::*;
  logic        i_clk_sys, i_rst, i_psel, i_penable, i_pwrite, slow, slv;
  logic        o_pready, o_pslverr, o_steal, o_irq, i_int_ack, i_mem_done;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [7:0]  i_ext_pin;
  logic        hwt;  // cpu in hardware trap service
  logic [27:0] evt;  // same-clock source event pulses
  logic [3:0]  i_cpu_prio;
  pie_vreq_s   o_vreq;
  pie_mov_s    o_mov;
  int          err_count, tests_run;
  pie_top #(.NUM_CH(NCH)) uut (.i_clk_sys, .i_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_ext_pin, .i_src_evt(evt), .i_cpu_prio, .i_int_ack,
    .i_hw_trap_active(hwt), .o_vreq, .o_steal, .o_mov, .i_mem_done,
    .o_irq);
  pie_cpu_model u_cpu (.i_clk_sys, .i_rst, .i_slow(slow), .i_vreq(o_vreq),
    .i_mov(o_mov), .o_int_ack(i_int_ack), .o_mem_done(i_mem_done));
  initial begin
    i_clk_sys = 0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  ////////////////////////////////////////////////////////////////////
  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge i_clk_sys);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
    @(posedge i_clk_sys);
    i_penable <= 1;
    n = 0;
    @(posedge i_clk_sys);
    while (o_pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge i_clk_sys);
    end
    if (o_pready !== 1'b1) err_count++;
    {rd, slv} = {o_prdata, o_pslverr};
    {i_psel, i_penable} <= 2'b00;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // bounded wait for a vectored request (s=0) or a stolen cycle (s=1)
  task automatic wt(input logic s);
    int n;
    n = 0;
    while ((s ? o_steal : o_vreq.vld) !== 1'b1 && n < 40) begin
      @(posedge i_clk_sys);
      #1 n++;
    end
    if ((s ? o_steal : o_vreq.vld) !== 1'b1) err_count++;
  endtask
  // expected vector is the trap number times four
  task automatic vchk(input logic [6:0] t);
    wt(0);
    chk({1'b0, o_vreq.trap, o_vreq.vec}, {1'b0, t, 15'h0, t, 2'b0});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000 err_count++;
    complete_run;
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    {i_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {1'b1, 47'h0};
    {i_ext_pin, i_cpu_prio, slow, hwt, evt, err_count, tests_run} = 0;
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 0;
    apb(0, 12'h000, 0); chk(rd, 0);
    apb(0, 12'h3FC, 0); chk({31'h0, slv}, 1);
    apb(1, 12'h204, 32'h0000_0001);
    i_cpu_prio <= 4'h5;
    apb(1, 12'h054, 32'h0000_00C5);
    repeat (10) @(posedge i_clk_sys);
    chk({31'h0, o_vreq.vld}, 0);
    i_cpu_prio <= 4'h4;
    vchk(7'h40);
    apb(0, 12'h200, 0); chk(rd & 32'h1, 1);
    chk({31'h0, o_irq}, 1);
    apb(1, 12'h200, 32'h0000_000F);
    repeat (2) @(posedge i_clk_sys);
    #1 chk({31'h0, o_irq}, 0);
    apb(1, 12'h20C, 32'h0000_0047); vchk(7'h47);
    apb(1, 12'h000, 32'h0000_1046);
    i_ext_pin <= 8'h01; vchk(7'h18);
    i_ext_pin <= 8'h00;
    repeat (10) @(posedge i_clk_sys);
    chk({31'h0, o_vreq.vld}, 0);
    slow <= 1;
    apb(1, 12'h100, 32'h0000_0202); apb(1, 12'h104, 32'h0000_1000);
    apb(1, 12'h108, 32'h0000_2000); apb(1, 12'h064, 32'h0000_01C7);
    wt(1); chk({o_mov.src, o_mov.dst}, 32'h1000_2000);
    chk({31'h0, o_vreq.vld}, 0);
    repeat (8) @(posedge i_clk_sys);
    apb(0, 12'h100, 0); chk(rd, 32'h0000_0201);
    apb(0, 12'h108, 0); chk(rd, 32'h0000_2001);
    apb(1, 12'h064, 32'h0000_01C7); wt(1);
    vchk(7'h44);
    repeat (6) @(posedge i_clk_sys);
    hwt <= 1;
    evt <= 28'h040_0000;
    apb(1, 12'h058, 32'h0000_0047);
    evt <= 0;
    repeat (10) @(posedge i_clk_sys);
    chk({31'h0, o_vreq.vld}, 0);
    apb(0, 12'h208, 0); chk(rd, 32'h0000_8994);
    hwt <= 0;
    vchk(7'h41);
    complete_run;
  end
endmodule
bind pie_top pie_chk #(.NUM_CH(NUM_CH)) u_chk (.i_clk_sys(i_clk_sys),
  .i_rst(i_rst), .i_hw_trap_active(i_hw_trap_active),
  .i_int_ack(i_int_ack), .i_mem_done(i_mem_done), .o_steal(o_steal),
  .o_pslverr(o_pslverr), .o_vreq(o_vreq), .o_mov(o_mov));
